//--- src/ata_passthrough_params.svh
`ifndef ATA_PASSTHROUGH_PARAMS_SVH
`define ATA_PASSTHROUGH_PARAMS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CMD0      6'h00
`define OFS_CMD3      6'h0C
`define OFS_CTRL      6'h10
`define OFS_STATUS    6'h14
`define OFS_IRQ_STAT  6'h18
`define OFS_IRQ_MASK  6'h1C
`define OFS_RDATA_LO  6'h20
`define OFS_RDATA_HI  6'h24
// ****************************************
// Field positions
// ****************************************
`define CTRL_START_BIT 0
`define CTRL_READ_BIT  1
`define STAT_BUSY_BIT  0
`define STAT_FAIL_BIT  1
`define STAT_SECT_LSB  8
`define STAT_SECT_MSB  16
`define IRQ_DONE_BIT   0
`define IRQ_FAIL_BIT   1
// ****************************************
// Reset values
// ****************************************
`define IRQ_RST        2'h0
`define SECTORS_RST    9'h000
// ****************************************
// Command block layout
// ****************************************
`define CB_BYTES       16
`define CB_MASK_BYTE   3
`define CB_COUNT_BYTE  4
`define CB_WDATA_BYTE  5
`define TF_REGS        8
`define SECTORS_ZERO   9'h100
// ****************************************
// Taskfile addresses
// ****************************************
`define TF_ADDR_CTRL   10'h3F6
`define TF_ADDR_BASE   10'h1F0
`endif

//--- src/ata_passthrough_pkg.sv
package ata_passthrough_pkg;
  // Command controller states
  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_RUN} ctl_state_t;
  // Taskfile walker states
  typedef enum logic [1:0] {SQ_IDLE, SQ_SCAN, SQ_ACCESS} seq_state_t;
endpackage

//--- src/taskfile_seq_if.sv
interface taskfile_seq_if;
  logic        start;      // One-cycle launch
  logic        read_mode;  // Read taskfile instead of write
  logic [7:0]  mask;       // Register selection
  logic [63:0] wbytes;     // Write bytes, byte k in lane k
  logic        busy;       // Walk in progress
  logic        done;       // One-cycle end of walk
  logic [63:0] rbytes;     // Read bytes, zero when unselected
  modport ctl (output start, read_mode, mask, wbytes, input busy, done, rbytes);
  modport seq (input start, read_mode, mask, wbytes, output busy, done, rbytes);
endinterface

//--- src/taskfile_sequencer.sv
`include "ata_passthrough_params.svh"
module taskfile_sequencer
  import ata_passthrough_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  taskfile_seq_if.seq     ctl,
  output logic            o_tf_req,
  output logic            o_tf_write,
  output logic [9:0]      o_tf_addr,
  output logic [7:0]      o_tf_wdata,
  input  wire logic       i_tf_ack,
  input  wire logic [7:0] i_tf_rdata
);
  seq_state_t  state, next_state;   // Walker state
  logic [2:0]  idx, next_idx;       // Current mask bit
  logic        done, next_done;     // End pulse
  logic        next_write;          // Direction of next access
  logic [9:0]  next_addr;           // Address of next access
  logic [7:0]  next_wdata;          // Data of next access
  logic [63:0] rbytes, next_rbytes; // Collected read bytes
  logic [63:0] sel_bits;            // Mask spread over byte lanes
  logic        clear;               // Start of walk
  logic        cap;                 // Read byte arrives

  assign o_tf_req   = (state == SQ_ACCESS);
  assign ctl.busy   = (state != SQ_IDLE);
  assign ctl.done   = done;
  assign ctl.rbytes = rbytes;
  assign clear      = (state == SQ_IDLE) && ctl.start;
  assign cap        = o_tf_req && i_tf_ack && !o_tf_write;

  // ****************************************
  // Read byte lanes
  // ****************************************
  for (genvar k = 0; k < `TF_REGS; k++) begin : g_lane
    // Unselected lanes stay zero after the clear
    assign next_rbytes[k*8 +: 8] = clear ? 8'h00 :
      (cap && idx == 3'(k)) ? i_tf_rdata : rbytes[k*8 +: 8];
    assign sel_bits[k*8 +: 8] = {8{ctl.mask[k]}};
  end

  // Walk the mask from bit 0 upward, one access at a time
  always_comb begin
    next_state = state;
    next_idx   = idx;
    next_done  = 1'b0;
    next_write = o_tf_write;
    next_addr  = o_tf_addr;
    next_wdata = o_tf_wdata;
    case (state)
      SQ_IDLE: begin
        if (ctl.start) begin
          next_idx   = 3'h0;
          next_state = SQ_SCAN;
        end
      end
      SQ_SCAN: begin
        if (ctl.mask[idx]) begin
          // Bit 0 is the control block, the rest the command block
          next_addr  = (idx == 3'h0) ? `TF_ADDR_CTRL : (`TF_ADDR_BASE | {7'h00, idx});
          // Bytes of unselected lanes are never looked at
          next_wdata = ctl.wbytes[{idx, 3'h0} +: 8];
          next_write = !ctl.read_mode;
          next_state = SQ_ACCESS;
        end else if (idx == 3'h7) begin
          next_done  = 1'b1;
          next_state = SQ_IDLE;
        end else begin
          next_idx = idx + 3'h1;
        end
      end
      SQ_ACCESS: begin
        // Held until the taskfile side acknowledges
        if (i_tf_ack) begin
          if (idx == 3'h7) begin
            next_done  = 1'b1;
            next_state = SQ_IDLE;
          end else begin
            next_idx   = idx + 3'h1;
            next_state = SQ_SCAN;
          end
        end
      end
      default: next_state = SQ_IDLE;
    endcase
  end

  // Register walker state
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state      <= SQ_IDLE;
      idx        <= 3'h0;
      done       <= 1'b0;
      o_tf_write <= 1'b0;
      o_tf_addr  <= 10'h000;
      o_tf_wdata <= 8'h00;
      rbytes     <= 64'h0;
    end else begin
      state      <= next_state;
      idx        <= next_idx;
      done       <= next_done;
      o_tf_write <= next_write;
      o_tf_addr  <= next_addr;
      o_tf_wdata <= next_wdata;
      rbytes     <= next_rbytes;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  property p_seq_order;
    ((o_tf_req && i_tf_ack) || (state == SQ_SCAN && !ctl.mask[idx])) && idx != 3'h7
      |=> idx == 3'($past(idx) + 3'h1);
  endproperty
  a_seq_order: assert property (p_seq_order) else $error("walk not ascending");

  property p_seq_sel;
    o_tf_req |-> ctl.mask[idx] &&
      o_tf_addr == ((idx == 3'h0) ? `TF_ADDR_CTRL : (`TF_ADDR_BASE | {7'h00, idx}));
  endproperty
  a_seq_sel: assert property (p_seq_sel) else $error("bad taskfile address");

  property p_seq_wdata;
    o_tf_req && o_tf_write |-> o_tf_wdata == ctl.wbytes[{idx, 3'h0} +: 8];
  endproperty
  a_seq_wdata: assert property (p_seq_wdata) else $error("wrong write byte");

  property p_seq_zero;
    ctl.done && ctl.read_mode |-> (rbytes & ~sel_bits) == 64'h0;
  endproperty
  a_seq_zero: assert property (p_seq_zero) else $error("unselected byte not zero");
endmodule

//--- src/ata_passthrough_block_decoder.sv
// Contract
// - Mask bit picks one taskfile register
// - Count byte gives sectors per block
// - Only powers of two; zero means 256
// - Illegal count completes with failure
// - Write bytes 5 to 12 feed taskfile
// - Unselected write bytes are ignored
// - Bytes 5..12 map ctrl through command
// - Accesses run bit 0 up to 7
// - Eight read bytes, unselected read zero
`include "ata_passthrough_params.svh"
module ata_passthrough_block_decoder
  import ata_passthrough_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic [5:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  input  wire logic [3:0]  i_byteenable,
  output logic [31:0]      o_readdata,
  output logic             o_waitrequest,
  output logic             o_irq,
  output logic             o_tf_req,
  output logic             o_tf_write,
  output logic [9:0]       o_tf_addr,
  output logic [7:0]       o_tf_wdata,
  input  wire logic        i_tf_ack,
  input  wire logic [7:0]  i_tf_rdata
);
  // ****************************************
  // Declarations
  // ****************************************
  taskfile_seq_if seq_if ();

  // Bus slave
  logic        bus_req;          // Any request present
  logic        bus_ack;          // Answer cycle
  logic        next_bus_ack;     // Next answer flag
  logic        bus_wr;           // Write takes effect now
  logic        bus_rd;           // Read data is computed now
  logic [31:0] next_readdata;    // Read data to latch
  logic [31:0] stat_word;        // Status register view

  // Command bytes as written, and the frozen copy
  logic [7:0]  cmd_buf [`CB_BYTES];
  logic [7:0]  next_cmd [`CB_BYTES];
  logic [7:0]  shadow [`CB_BYTES];
  logic [7:0]  next_shadow [`CB_BYTES];

  // Control
  ctl_state_t  ctl_state;        // Controller state
  ctl_state_t  next_ctl_state;   // Next controller state
  logic        read_cfg;         // Read mode as programmed
  logic        next_read_cfg;
  logic        read_run;         // Read mode of running command
  logic        next_read_run;
  logic        capture;          // Start accepted this cycle
  logic [7:0]  count;            // Frozen block count byte
  logic        legal;            // Count is in the legal set
  logic [8:0]  sectors;          // Sectors per block
  logic [8:0]  next_sectors;
  logic        failed;           // Last command failed
  logic        next_failed;

  // Interrupts
  logic [1:0]  irq_stat;         // Sticky events
  logic [1:0]  next_irq_stat;
  logic [1:0]  irq_mask;         // Enables
  logic [1:0]  next_irq_mask;
  logic [1:0]  irq_set;          // Events this cycle
  logic [1:0]  irq_clr;          // Write-one-to-clear
  logic        next_irq;

  // ****************************************
  // Avalon-MM slave handshake
  // ****************************************
  // Fixed one wait cycle: data is looked up in the first
  // cycle and driven from a flop in the second, so the
  // read mux never sits on the output path.
  assign bus_req       = i_read || i_write;
  assign o_waitrequest = bus_req && !bus_ack;
  assign next_bus_ack  = bus_req && !bus_ack;
  assign bus_wr        = i_write && bus_ack;
  assign bus_rd        = i_read && !bus_ack;

  // Status word assembly
  always_comb begin
    stat_word = 32'h0;
    stat_word[`STAT_BUSY_BIT] = (ctl_state != ST_IDLE);
    stat_word[`STAT_FAIL_BIT] = failed;
    stat_word[`STAT_SECT_MSB:`STAT_SECT_LSB] = sectors;
  end

  // Read mux, unmapped offsets read as zero
  always_comb begin
    next_readdata = o_readdata;
    if (bus_rd) begin
      if (i_address <= `OFS_CMD3) begin
        next_readdata = {cmd_buf[{i_address[3:2], 2'h3}],
                         cmd_buf[{i_address[3:2], 2'h2}],
                         cmd_buf[{i_address[3:2], 2'h1}],
                         cmd_buf[{i_address[3:2], 2'h0}]};
      end else if (i_address == `OFS_CTRL) begin
        next_readdata = {30'h0, read_cfg, 1'b0};
      end else if (i_address == `OFS_STATUS) begin
        next_readdata = stat_word;
      end else if (i_address == `OFS_IRQ_STAT) begin
        next_readdata = {30'h0, irq_stat};
      end else if (i_address == `OFS_IRQ_MASK) begin
        next_readdata = {30'h0, irq_mask};
      end else if (i_address == `OFS_RDATA_LO) begin
        next_readdata = seq_if.rbytes[31:0];
      end else if (i_address == `OFS_RDATA_HI) begin
        next_readdata = seq_if.rbytes[63:32];
      end else begin
        next_readdata = 32'h0;
      end
    end
  end

  // Register the bus slave
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      bus_ack    <= 1'b0;
      o_readdata <= 32'h0;
    end else begin
      bus_ack    <= next_bus_ack;
      o_readdata <= next_readdata;
    end
  end

  // ****************************************
  // Command block bytes
  // ****************************************
  // A start while busy is dropped, so the frozen copy
  // only ever changes between commands.
  assign capture = bus_wr && (i_address == `OFS_CTRL) && i_byteenable[0] &&
                   i_writedata[`CTRL_START_BIT] && (ctl_state == ST_IDLE);

  for (genvar k = 0; k < `CB_BYTES; k++) begin : g_cb
    // Byte k sits in word k/4, lane k%4
    assign next_cmd[k] =
      (bus_wr && i_byteenable[k % 4] && i_address == 6'(`OFS_CMD0 + 4 * (k / 4))) ?
      i_writedata[(k % 4) * 8 +: 8] : cmd_buf[k];
    // Copy all sixteen bytes at once
    assign next_shadow[k] = capture ? cmd_buf[k] : shadow[k];
    // Write bytes go to the walker in lane order
    if (k >= `CB_WDATA_BYTE && k < `CB_WDATA_BYTE + `TF_REGS) begin : g_wb
      assign seq_if.wbytes[(k - `CB_WDATA_BYTE) * 8 +: 8] = shadow[k];
    end
  end

  // Register command bytes; the trailing three are stored
  // but never checked, the host keeps them zero
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      for (int k = 0; k < `CB_BYTES; k++) begin
        cmd_buf[k] <= 8'h00;
        shadow[k]  <= 8'h00;
      end
    end else begin
      for (int k = 0; k < `CB_BYTES; k++) begin
        cmd_buf[k] <= next_cmd[k];
        shadow[k]  <= next_shadow[k];
      end
    end
  end

  // ****************************************
  // Command controller
  // ****************************************
  assign count = shadow[`CB_COUNT_BYTE];
  // Zero or a single set bit
  assign legal = ((count & (count - 8'h01)) == 8'h00);

  assign seq_if.mask      = shadow[`CB_MASK_BYTE];
  assign seq_if.read_mode = read_run;
  assign seq_if.start     = (ctl_state == ST_CHECK) && legal;

  // Controller next state and events
  always_comb begin
    next_ctl_state = ctl_state;
    next_sectors   = sectors;
    next_failed    = failed;
    next_read_run  = read_run;
    next_read_cfg  = read_cfg;
    irq_set        = 2'h0;
    if (bus_wr && i_address == `OFS_CTRL && i_byteenable[0]) begin
      next_read_cfg = i_writedata[`CTRL_READ_BIT];
    end
    case (ctl_state)
      ST_IDLE: begin
        if (capture) begin
          // Mode written with the start bit is the one used
          next_read_run  = i_writedata[`CTRL_READ_BIT];
          next_ctl_state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        // The count is trusted to match the drive
        if (legal) begin
          next_sectors   = (count == 8'h00) ? `SECTORS_ZERO : {1'b0, count};
          next_failed    = 1'b0;
          next_ctl_state = ST_RUN;
        end else begin
          // No taskfile access on an illegal count
          next_failed    = 1'b1;
          irq_set        = 2'h3;
          next_ctl_state = ST_IDLE;
        end
      end
      ST_RUN: begin
        if (seq_if.done) begin
          irq_set[`IRQ_DONE_BIT] = 1'b1;
          next_ctl_state = ST_IDLE;
        end
      end
      default: next_ctl_state = ST_IDLE;
    endcase
  end

  // Register controller state
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ctl_state <= ST_IDLE;
      sectors   <= `SECTORS_RST;
      failed    <= 1'b0;
      read_run  <= 1'b0;
      read_cfg  <= 1'b0;
    end else begin
      ctl_state <= next_ctl_state;
      sectors   <= next_sectors;
      failed    <= next_failed;
      read_run  <= next_read_run;
      read_cfg  <= next_read_cfg;
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  assign irq_clr = (bus_wr && i_address == `OFS_IRQ_STAT && i_byteenable[0]) ?
                   i_writedata[1:0] : 2'h0;

  // Set beats clear so no event is lost
  always_comb begin
    next_irq_stat = (irq_stat & ~irq_clr) | irq_set;
    next_irq_mask = irq_mask;
    if (bus_wr && i_address == `OFS_IRQ_MASK && i_byteenable[0]) begin
      next_irq_mask = i_writedata[1:0];
    end
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  // Register interrupt state
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      irq_stat <= `IRQ_RST;
      irq_mask <= `IRQ_RST;
      o_irq    <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      o_irq    <= next_irq;
    end
  end

  // ****************************************
  // Taskfile walker
  // ****************************************
  taskfile_sequencer u_seq (
    .i_mclk     (i_mclk),
    .i_rst      (i_rst),
    .ctl        (seq_if.seq),
    .o_tf_req   (o_tf_req),
    .o_tf_write (o_tf_write),
    .o_tf_addr  (o_tf_addr),
    .o_tf_wdata (o_tf_wdata),
    .i_tf_ack   (i_tf_ack),
    .i_tf_rdata (i_tf_rdata)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  property p_fail;
    ctl_state == ST_CHECK && !legal |=> irq_stat == 2'h3 && failed &&
      ctl_state == ST_IDLE ##1 !o_tf_req;
  endproperty
  a_fail: assert property (p_fail) else $error("illegal count not failed");

  property p_zero;
    ctl_state == ST_CHECK && count == 8'h00 |=> sectors == `SECTORS_ZERO;
  endproperty
  a_zero: assert property (p_zero) else $error("zero count not 256");

  property p_count;
    ctl_state == ST_CHECK && legal && count != 8'h00 |=> sectors == {1'b0, $past(count)};
  endproperty
  a_count: assert property (p_count) else $error("sector count wrong");

  property p_stable;
    ctl_state != ST_IDLE |=> $stable(seq_if.wbytes) && $stable(seq_if.mask);
  endproperty
  a_stable: assert property (p_stable) else $error("block changed in flight");

  property p_wait;
    bus_req && o_waitrequest |=> !o_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("waitrequest over one cycle");

  // Walker only runs inside an accepted command
  property p_busy;
    seq_if.busy |-> ctl_state == ST_RUN;
  endproperty
  a_busy: assert property (p_busy) else $error("walk outside command");
endmodule

//--- testbench/taskfile_drive_model.sv
// ****
// Taskfile drive model
// ****
module taskfile_drive_model (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic [3:0] i_delay,
  input  wire logic       i_tf_req,
  input  wire logic       i_tf_write,
  input  wire logic [9:0] i_tf_addr,
  input  wire logic [7:0] i_tf_wdata,
  output logic            o_tf_ack,
  output logic [7:0]      o_tf_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_cnt;       // Cycles the drive has stalled
  logic [9:0] log_addr [64];  // Completed access addresses
  logic       log_wr   [64];  // Completed access direction
  logic [7:0] log_data [64];  // Bytes written by the block
  int         log_cnt;        // Accesses seen so far
  // Ack after a settable stall; read bus churns when idle so stale data never matches
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_tf_ack   <= 1'b0;
      wait_cnt   <= 4'h0;
      log_cnt    <= 0;
      o_tf_rdata <= 8'h00;
    end else if (o_tf_ack) begin
      // Access completes here; every access is logged, read or write
      log_addr[log_cnt] <= i_tf_addr;
      log_wr[log_cnt]   <= i_tf_write;
      log_data[log_cnt] <= i_tf_wdata;
      log_cnt           <= log_cnt + 1;
      o_tf_ack          <= 1'b0;
      wait_cnt          <= 4'h0;
      o_tf_rdata        <= ~o_tf_rdata;
    end else if (i_tf_req && wait_cnt == i_delay) begin
      o_tf_ack   <= 1'b1;
      o_tf_rdata <= i_tf_addr[7:0] ^ 8'h5A;  // Register byte is a function of address
    end else begin
      wait_cnt   <= i_tf_req ? wait_cnt + 4'h1 : 4'h0;
      o_tf_rdata <= ~o_tf_rdata;
    end
  end
endmodule

//--- testbench/tb.sv
`include "ata_passthrough_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_mclk, i_rst, i_read, i_write, i_tf_ack, o_tf_req, o_tf_write;
  logic [5:0]  i_address;
  logic [31:0] i_writedata, o_readdata;
  logic [3:0]  i_byteenable, tf_delay;
  logic        o_waitrequest, o_irq;
  logic [9:0]  o_tf_addr;
  logic [7:0]  o_tf_wdata, i_tf_rdata;
  logic [7:0]  cb [16];      // Command block as the host built it
  logic [31:0] rd;           // Last bus read
  int          fail_count;   // Mismatches
  int          n_compared;   // Comparisons
  int          base;         // Access log position before a command
  ata_passthrough_block_decoder dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_irq(o_irq),
    .o_tf_req(o_tf_req), .o_tf_write(o_tf_write), .o_tf_addr(o_tf_addr),
    .o_tf_wdata(o_tf_wdata), .i_tf_ack(i_tf_ack), .i_tf_rdata(i_tf_rdata));
  taskfile_drive_model tf_model (.i_mclk(i_mclk), .i_rst(i_rst), .i_delay(tf_delay),
    .i_tf_req(o_tf_req), .i_tf_write(o_tf_write), .i_tf_addr(o_tf_addr),
    .i_tf_wdata(o_tf_wdata), .o_tf_ack(i_tf_ack), .o_tf_rdata(i_tf_rdata));
  // ****
  // Helpers
  // ****
  task automatic close_out();
    if (fail_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask
  // Avalon write; extra edge after release so the next request never lands in the same step
  task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
    int n;
    i_address   <= a;
    i_writedata <= d;
    i_write     <= 1'b1;
    n = 0;
    do begin @(posedge i_mclk); n++; end while (o_waitrequest !== 1'b0 && n < 64);
    // A bus that never answers counts against the run
    if (o_waitrequest !== 1'b0) fail_count++;
    i_write <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic bus_rd(input logic [5:0] a);
    int n;
    i_address <= a;
    i_read    <= 1'b1;
    n = 0;
    do begin @(posedge i_mclk); n++; end while (o_waitrequest !== 1'b0 && n < 64);
    if (o_waitrequest !== 1'b0) fail_count++;
    rd = o_readdata;
    i_read <= 1'b0;
    @(posedge i_mclk);
  endtask
  // Build and send a block; reserved tail left zero count as the host set it
  task automatic load_cb(input logic [7:0] m, input logic [7:0] c);
    for (int k = 0; k < 16; k++) cb[k] = (k >= 5 && k <= 12) ? 8'(8'hC0 + k) : 8'h00;
    cb[3] = m;
    cb[4] = c;
    for (int w = 0; w < 4; w++) bus_wr(6'(4 * w), {cb[4*w+3], cb[4*w+2], cb[4*w+1], cb[4*w]});
    bus_wr(`OFS_IRQ_STAT, 32'h0000_0003);
    base = tf_model.log_cnt;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin bus_rd(`OFS_STATUS); n++; end while (rd[0] !== 1'b0 && n < 200);
    // A command that never finishes counts against the run
    if (rd[0] !== 1'b0) fail_count++;
  endtask
  // Selected registers only, ascending, right address and byte
  task automatic chk_walk(input logic [7:0] m, input logic wr);
    int i;
    i = base;
    for (int k = 0; k < 8; k++) begin
      if (m[k]) begin
        chk("tf_addr", (k == 0) ? 32'h3F6 : 32'h1F0 + k, tf_model.log_addr[i]);
        chk("tf_write", wr, tf_model.log_wr[i]);
        if (wr) chk("tf_wdata", cb[5+k], tf_model.log_data[i]);
        i++;
      end
    end
    chk("tf_count", i, tf_model.log_cnt);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_write_walk();
    load_cb(8'h05, 8'h01);
    bus_wr(`OFS_CTRL, 32'h0000_0001);
    wait_idle();
    chk_walk(8'h05, 1'b1);
    chk("status", 32'h0000_0100, rd);
    bus_rd(`OFS_IRQ_STAT);
    chk("irq_stat", 32'h1, rd);
  endtask
  // Every legal count; zero reads back as 256
  task automatic t_counts();
    logic [7:0] legal [9];
    legal = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
    foreach (legal[j]) begin
      load_cb(8'h00, legal[j]);
      bus_wr(`OFS_CTRL, 32'h0000_0001);
      wait_idle();
      chk("sectors", (legal[j] == 8'h00) ? 32'h0001_0000 : {16'h0, legal[j], 8'h00}, rd);
    end
  endtask
  // Illegal counts fail with no taskfile access and keep the old size
  task automatic t_illegal();
    logic [7:0] bad [3];
    bad = '{8'h03, 8'h81, 8'hFF};
    foreach (bad[j]) begin
      load_cb(8'hFF, bad[j]);
      bus_wr(`OFS_CTRL, 32'h0000_0001);
      wait_idle();
      chk("status", 32'h0000_8002, rd);
      chk("tf_count", base, tf_model.log_cnt);
      bus_rd(`OFS_IRQ_STAT);
      chk("irq_stat", 32'h3, rd);
    end
  endtask
  // Read mode with a slow drive: eight bytes, unselected zero
  task automatic t_read_walk();
    tf_delay <= 4'h3;
    load_cb(8'hA2, 8'h08);
    bus_wr(`OFS_CTRL, 32'h0000_0003);
    wait_idle();
    chk_walk(8'hA2, 1'b0);
    bus_rd(`OFS_RDATA_LO);
    chk("rdata_lo", 32'h0000_AB00, rd);
    bus_rd(`OFS_RDATA_HI);
    chk("rdata_hi", 32'hAD00_AF00, rd);
  endtask
  // Block rewritten and restarted mid-walk; the captured copy must win
  task automatic t_capture();
    tf_delay <= 4'h9;
    load_cb(8'hFF, 8'h02);
    bus_wr(`OFS_CTRL, 32'h0000_0001);
    bus_wr(6'h04, 32'h1122_3303);
    bus_wr(`OFS_CTRL, 32'h0000_0003);
    wait_idle();
    chk_walk(8'hFF, 1'b1);
    chk("status", 32'h0000_0200, rd);
  endtask
  // Masking, level output, write-one-to-clear, unmapped place
  task automatic t_irq();
    chk("irq_masked", 1'b0, o_irq);
    bus_wr(`OFS_IRQ_MASK, 32'h2);
    chk("irq_other", 1'b0, o_irq);
    bus_wr(`OFS_IRQ_MASK, 32'h1);
    chk("irq_on", 1'b1, o_irq);
    bus_wr(`OFS_IRQ_STAT, 32'h1);
    chk("irq_off", 1'b0, o_irq);
    bus_wr(6'h3C, 32'hFFFF_FFFF);
    bus_rd(6'h3C);
    chk("unmapped", 32'h0, rd);
    // Mode bit reads back, start bit reads zero
    bus_rd(`OFS_CTRL);
    chk("ctrl_mode", 32'h2, rd);
    // Only the enabled lane of a command word changes
    i_byteenable <= 4'h2;
    bus_wr(`OFS_CMD0, 32'hAAAA_AAAA);
    i_byteenable <= 4'hF;
    bus_rd(`OFS_CMD0);
    chk("cmd0_lane", 32'hFF00_AA00, rd);
  endtask
  // ****
  // Clock, reset, sequence, watchdog
  // ****
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  initial begin
    {i_read, i_write, i_address, i_writedata, fail_count, n_compared} = '0;
    i_byteenable = 4'hF;
    tf_delay = 4'h0;
    i_rst = 1'b1;
    repeat (12) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    bus_rd(`OFS_STATUS);
    chk("status_rst", 32'h0, rd);
    t_write_walk();
    t_counts();
    t_illegal();
    t_read_walk();
    t_capture();
    t_irq();
    close_out();
  end
  initial begin
    repeat (30000) @(posedge i_mclk);
    fail_count++;
    close_out();
  end
endmodule
